//--- pkg/rpa_defs.svh
// Constants of the run-time parameter access window: register numbers, fields, counts.
// Assumes inclusion by bare name from the design files.
`ifndef RPA_DEFS_SVH
`define RPA_DEFS_SVH

// Register numbers on the Modbus side, identical on every interface module variant.
`define RPA_REQ_BASE  16'hB04A
`define RPA_REQ_WORDS 5
`define RPA_RSP_BASE  16'hB04F
`define RPA_RSP_WORDS 4
// Field positions inside the first request word.
`define RPA_SUB_MSB   15
`define RPA_SUB_LSB   8
`define RPA_TGL_BIT   7
`define RPA_LEN_MSB   6
// Longest data transfer in bytes; a length of zero asks for a read.
`define RPA_MAX_LEN   7'h04
// Cycles to wait for the parameter store before answering with an error.
`define RPA_ACK_WAIT  1000
`define RPA_RST_WORD  16'h0000

`endif

//--- pkg/rpa_pkg.sv
// Types shared by the run-time parameter access window.
// Assumes nothing of its surroundings.
package rpa_pkg;
	typedef enum {RPA_IDLE, RPA_WAIT} rpa_state_t;
	typedef enum logic {RPA_SRC_MASTER, RPA_SRC_PANEL} rpa_src_t;
endpackage

//--- core/rpa_word.sv
// One 16-bit request word of the access window, writable and clearable.
// Assumes the caller decodes the write enable and the clear.
`timescale 1ns/100ps
`include "rpa_defs.svh"

module rpa_word (
	input  wire logic        clk,   // System clock.
	input  wire logic        nrst,  // Synchronous reset, active low.
	input  wire logic        we,    // Write strobe for this word.
	input  wire logic        clr,   // Revert the word to its reset value.
	input  wire logic [15:0] d,     // Write data.
	output logic      [15:0] q      // Stored word.
);
	logic [15:0] q_next;

	// A clear beats a write so a reverted request cannot survive.
	always_comb begin
		q_next = q;
		if (clr) begin
			q_next = `RPA_RST_WORD;
		end else if (we) begin
			q_next = d;
		end
	end

	// Register only.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			q <= `RPA_RST_WORD;
		end else begin
			q <= q_next;
		end
	end
endmodule

//--- core/rpa_core.sv
// Run-time parameter access window: request and response words and the request engine.
// Assumes a register port already decoded from Modbus commands and a parameter store
// that answers each request with one ack pulse.
`timescale 1ns/100ps
`include "rpa_defs.svh"

// Overview of operation
// R1: Five request words in the output image.
// R2: Four read-only response words in input image.
// R3: Window absent unless configuration enables it.
// R4: Window sits after process data, before panel.
// R5: Register numbers fixed on every module variant.
// R6: Reset, store, hot swap revert changed parameters.
// R7: Test mode ignores fieldbus master request writes.
// R8: Plain register reads and writes reach words.
// R9: First word: sub-index, toggle and length.
// R10: Then index, then four data bytes, LSB first.
// R11: Toggle change starts exactly one execution; a length above 4 gets an error answer and no request.
// R12: Hot-swap flag and module number are readable.
module rpa_core #(
	parameter int ACK_WAIT = `RPA_ACK_WAIT
) (
	input  wire logic              clk,             // System clock, 20 MHz.
	input  wire logic              nrst,            // Synchronous reset, active low.
	input  wire logic              cfg_enable,      // Window enabled by configuration.
	input  wire logic              test_mode,       // Island is in test mode.
	input  wire logic              reg_wr,          // Register write strobe.
	input  wire logic              reg_rd,          // Register read strobe.
	input  rpa_pkg::rpa_src_t      reg_src,         // Who issues the access.
	input  wire logic [15:0]       reg_addr,        // Modbus register number.
	input  wire logic [15:0]       reg_wdata,       // Write data.
	input  wire logic              revert_cmd,      // Reset or store-to-card command.
	input  wire logic              hot_swap,        // A module was hot-swapped.
	input  wire logic [7:0]        hot_swap_module, // Number of that module.
	input  wire logic              param_ack,       // Parameter store finished.
	input  wire logic              param_err,       // Parameter store refused.
	input  wire logic [31:0]       param_rdata,     // Parameter value read.
	output logic                   reg_ack,         // Access hit the window.
	output logic                   reg_err,         // Write was refused.
	output logic      [15:0]       reg_rdata,       // Read data.
	output logic                   param_req,       // One-cycle request to the store.
	output logic                   param_we,        // Request is a write.
	output logic      [15:0]       param_index,     // Parameter index.
	output logic      [7:0]        param_subidx,    // Parameter sub-index.
	output logic      [6:0]        param_len,       // Data length in bytes.
	output logic      [31:0]       param_wdata,     // Data to write.
	output logic                   param_revert,    // Store returns to configured values.
	output logic                   hot_swap_flag    // Sticky hot-swap status.
);
	localparam int CW = $clog2(ACK_WAIT + 1);

	logic [15:0] req_word [`RPA_REQ_WORDS];
	logic [`RPA_REQ_WORDS-1:0] word_we;
	logic [15:0] req_off;
	logic [15:0] rsp_off;
	logic        req_hit;
	logic        rsp_hit;
	logic        wr_block;
	logic        revert;
	logic [2:0]  idx;

	// Decode of the fixed register numbers; nothing answers while the window is off.
	always_comb begin
		req_off  = reg_addr - `RPA_REQ_BASE;
		rsp_off  = reg_addr - `RPA_RSP_BASE;
		req_hit  = cfg_enable && (req_off < 16'(`RPA_REQ_WORDS)); // R3 R4 R5
		rsp_hit  = cfg_enable && (rsp_off < 16'(`RPA_RSP_WORDS)); // R2 R4 R5
		idx      = req_hit ? req_off[2:0] : rsp_off[2:0];
		wr_block = test_mode && (reg_src == rpa_pkg::RPA_SRC_MASTER); // R7
		revert   = revert_cmd || hot_swap; // R6
		for (int i = 0; i < `RPA_REQ_WORDS; i++) begin
			word_we[i] = reg_wr && req_hit && !wr_block && (idx == 3'(i)); // R1 R8
		end
	end

	// The request words; a revert also clears them so no stale request reruns.
	genvar gi;
	generate
		for (gi = 0; gi < `RPA_REQ_WORDS; gi++) begin : g_req
			rpa_word u_word (
				.clk  (clk),
				.nrst (nrst),
				.we   (word_we[gi]),
				.clr  (revert),
				.d    (reg_wdata),
				.q    (req_word[gi])
			);
		end
	endgenerate

	rpa_pkg::rpa_state_t state_reg, state_next;
	logic          last_tgl_reg, last_tgl_next;
	logic [CW-1:0] cnt_reg, cnt_next;
	logic [15:0]   rsp_reg [`RPA_RSP_WORDS];
	logic [15:0]   rsp_next [`RPA_RSP_WORDS];
	logic          hs_flag_next;
	logic [7:0]    hs_mod_reg, hs_mod_next;
	logic          req_next, we_next, revert_next;
	logic [15:0]   index_next;
	logic [7:0]    subidx_next;
	logic [6:0]    len_next;
	logic [31:0]   wdata_next;
	logic          done;
	logic          done_err;
	logic [31:0]   done_data;
	logic          tgl;
	logic [6:0]    len;

	// Request engine: a toggle change runs one access, or none for a length above 4, and the answer is echoed with the toggle.
	always_comb begin
		tgl           = req_word[0][`RPA_TGL_BIT]; // R9
		len           = req_word[0][`RPA_LEN_MSB:0]; // R9
		state_next    = state_reg;
		last_tgl_next = last_tgl_reg;
		cnt_next      = cnt_reg;
		req_next      = 1'b0;
		we_next       = param_we;
		index_next    = param_index;
		subidx_next   = param_subidx;
		len_next      = param_len;
		wdata_next    = param_wdata;
		done          = 1'b0;
		done_err      = 1'b0;
		done_data     = param_wdata;
		case (state_reg)
			rpa_pkg::RPA_IDLE: begin
				if (cfg_enable && (tgl != last_tgl_reg)) begin
					last_tgl_next = tgl; // R11
					index_next    = req_word[1]; // R10
					subidx_next   = req_word[0][`RPA_SUB_MSB:`RPA_SUB_LSB]; // R9
					len_next      = len;
					wdata_next    = {req_word[3], req_word[2]}; // R10
					we_next       = (len != 7'h00);
					if (len > `RPA_MAX_LEN) begin
						done     = 1'b1;
						done_err = 1'b1;
					end else begin
						req_next   = 1'b1; // R11
						cnt_next   = '0;
						state_next = rpa_pkg::RPA_WAIT;
					end
				end
			end
			rpa_pkg::RPA_WAIT: begin
				if (param_ack) begin
					done       = 1'b1;
					done_err   = param_err;
					done_data  = param_we ? param_wdata : param_rdata;
					state_next = rpa_pkg::RPA_IDLE;
				end else if (cnt_reg == CW'(ACK_WAIT - 1)) begin
					// A silent store must not hang the window forever.
					done       = 1'b1;
					done_err   = 1'b1;
					state_next = rpa_pkg::RPA_IDLE;
				end else begin
					cnt_next = cnt_reg + CW'(1);
				end
			end
			default: begin
				state_next = rpa_pkg::RPA_IDLE;
			end
		endcase
		for (int i = 0; i < `RPA_RSP_WORDS; i++) begin
			rsp_next[i] = rsp_reg[i];
		end
		if (done) begin
			rsp_next[0] = {8'h00, tgl, done_err, 3'b000, len_next[2:0]};
			rsp_next[1] = index_next;
			rsp_next[2] = done_data[15:0];
			rsp_next[3] = done_data[31:16];
		end
		// A finished request clears the hot-swap flag, but a new swap wins.
		hs_flag_next = (hot_swap_flag && !done) || hot_swap; // R12
		hs_mod_next  = hot_swap ? hot_swap_module : hs_mod_reg; // R12
		revert_next  = revert; // R6
		if (revert) begin
			state_next    = rpa_pkg::RPA_IDLE; // R6
			last_tgl_next = 1'b0;
			req_next      = 1'b0;
		end
	end

	// Register only.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_reg     <= rpa_pkg::RPA_IDLE;
			last_tgl_reg  <= 1'b0;
			cnt_reg       <= '0;
			hot_swap_flag <= 1'b0;
			hs_mod_reg    <= 8'h00;
			param_req     <= 1'b0;
			param_we      <= 1'b0;
			param_index   <= 16'h0000;
			param_subidx  <= 8'h00;
			param_len     <= 7'h00;
			param_wdata   <= 32'h00000000;
			param_revert  <= 1'b0;
			for (int i = 0; i < `RPA_RSP_WORDS; i++) begin
				rsp_reg[i] <= `RPA_RST_WORD;
			end
		end else begin
			state_reg     <= state_next;
			last_tgl_reg  <= last_tgl_next;
			cnt_reg       <= cnt_next;
			hot_swap_flag <= hs_flag_next;
			hs_mod_reg    <= hs_mod_next;
			param_req     <= req_next;
			param_we      <= we_next;
			param_index   <= index_next;
			param_subidx  <= subidx_next;
			param_len     <= len_next;
			param_wdata   <= wdata_next;
			param_revert  <= revert_next;
			for (int i = 0; i < `RPA_RSP_WORDS; i++) begin
				rsp_reg[i] <= rsp_next[i];
			end
		end
	end

	logic        ack_next;
	logic        err_next;
	logic [15:0] rdata_next;

	// Register port answer one cycle after the strobe; response words are read-only.
	always_comb begin
		ack_next   = (reg_wr || reg_rd) && (req_hit || rsp_hit); // R8
		err_next   = reg_wr && (rsp_hit || (req_hit && wr_block)); // R2 R7
		rdata_next = 16'h0000;
		if (reg_rd && req_hit) begin
			rdata_next = req_word[idx]; // R9
		end else if (reg_rd && rsp_hit && (idx == 3'h0)) begin
			rdata_next = {hs_mod_reg, rsp_reg[0][7:6], hot_swap_flag, rsp_reg[0][4:0]}; // R12
		end else if (reg_rd && rsp_hit) begin
			rdata_next = rsp_reg[idx[1:0]];
		end
	end

	// Register only.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			reg_ack   <= 1'b0;
			reg_err   <= 1'b0;
			reg_rdata <= 16'h0000;
		end else begin
			reg_ack   <= ack_next;
			reg_err   <= err_next;
			reg_rdata <= rdata_next;
		end
	end

	sequence s_new_toggle;
		(state_reg == rpa_pkg::RPA_IDLE) && cfg_enable && !revert
			&& (tgl != last_tgl_reg) && (len <= `RPA_MAX_LEN);
	endsequence

	sequence s_master_write;
		reg_wr && req_hit && wr_block && !revert;
	endsequence

	a_toggle_starts: assert property (@(posedge clk) disable iff (!nrst)
		s_new_toggle |=> param_req && (param_subidx == $past(req_word[0][15:8]))) // R11
		else $error("toggle change did not start a request");
	a_single_exec: assert property (@(posedge clk) disable iff (!nrst)
		param_req |=> !param_req) // R11
		else $error("request repeated");
	a_index_data: assert property (@(posedge clk) disable iff (!nrst)
		param_req |-> (param_index == $past(req_word[1]))
			&& (param_wdata == {$past(req_word[3]), $past(req_word[2])})) // R10
		else $error("index or data words misplaced");
	a_master_blocked: assert property (@(posedge clk) disable iff (!nrst)
		s_master_write |=> reg_ack && reg_err
			&& (req_word[$past(idx)] == $past(req_word[idx]))) // R7
		else $error("master write taken in test mode");
	a_req_write_ok: assert property (@(posedge clk) disable iff (!nrst)
		reg_wr && req_hit && !wr_block && !revert |=> reg_ack && !reg_err
			&& (req_word[$past(idx)] == $past(reg_wdata))) // R1
		else $error("request word write lost");
	a_rsp_readonly: assert property (@(posedge clk) disable iff (!nrst)
		reg_wr && rsp_hit |=> reg_ack && reg_err) // R2
		else $error("response write not refused");
	a_window_absent: assert property (@(posedge clk) disable iff (!nrst)
		!cfg_enable |=> !reg_ack && !param_req) // R3
		else $error("window answered while disabled");
	a_revert_clears: assert property (@(posedge clk) disable iff (!nrst)
		revert |=> param_revert && (req_word[0] == 16'h0000) && !param_req) // R6
		else $error("revert did not clear request");
	a_hs_flag: assert property (@(posedge clk) disable iff (!nrst)
		hot_swap |=> hot_swap_flag && (hs_mod_reg == $past(hot_swap_module))) // R12
		else $error("hot swap not flagged");
endmodule

//--- test/rpa_store_model.sv
// Parameter store model that stands behind the access window.
// Assumes the bench sets delay, mode and read value before each request.
`timescale 1ns/100ps
module rpa_store_model (
	input  wire logic        clk,        // System clock.
	input  wire logic        param_req,  // Request pulse from the window.
	input  wire logic [3:0]  delay,      // Wait cycles; the ack comes delay+1 edges after the request is sampled.
	input  wire logic [1:0]  mode,       // 0 accept, 1 refuse, 2 stay silent.
	input  wire logic [31:0] rd_val,     // Value returned with the ack.
	output logic             param_ack,  // Store finished.
	output logic             param_err,  // Store refused.
	output logic      [31:0] param_rdata // Read value, garbage outside the ack.
);
	int cnt = -1;
	// Quiet outputs until the first clock edge.
	initial begin
		param_ack = 1'b0;
		param_err = 1'b0;
		param_rdata = 32'h0000_0000;
	end
	// Counts down after each request; silent mode never acks, to provoke the timeout.
	always @(posedge clk) begin
		param_ack <= 1'b0;
		param_err <= 1'b0;
		param_rdata <= ~param_rdata; // A released bus must not show a stale value.
		if (param_req) begin
			cnt <= (mode == 2'h2) ? -1 : int'(delay);
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end else if (cnt == 0) begin
			cnt <= -1;
			param_ack <= 1'b1;
			param_err <= mode == 2'h1;
			param_rdata <= rd_val;
		end
	end
endmodule

//--- test/tb_top.sv
// Bench for the parameter access window: register map, requests, reverts and faults.
// Assumes the store model beside it and a 20 MHz clock.
`timescale 1ns/100ps
module tb_top;
	logic               clk = 1'b0;
	logic               nrst = 1'b0;
	logic               cfg_enable = 1'b1;
	logic               test_mode = 1'b0;
	logic               reg_wr = 1'b0;
	logic               reg_rd = 1'b0;
	rpa_pkg::rpa_src_t  reg_src = rpa_pkg::RPA_SRC_MASTER;
	logic        [15:0] reg_addr = 16'h0000;
	logic        [15:0] reg_wdata = 16'h0000;
	logic               revert_cmd = 1'b0;
	logic               hot_swap = 1'b0;
	logic        [7:0]  hot_swap_module = 8'h00;
	logic               param_ack, param_err, reg_ack, reg_err, param_req, param_we;
	logic               param_revert, hot_swap_flag, ak, er;
	logic        [31:0] param_rdata, param_wdata, rd_val, dat;
	logic        [15:0] reg_rdata, param_index, idx, q;
	logic        [7:0]  param_subidx, sub, mod = 8'h00;
	logic        [6:0]  param_len;
	logic        [3:0]  delay = 4'h0;
	logic        [1:0]  mode = 2'h0;
	logic               tg = 1'b0;
	int                 err_count = 0;
	int                 checks = 0;
	int                 nreq = 0;
	int                 k, n;
	int                 exp_q[$];

	rpa_core #(.ACK_WAIT(8)) dut (.clk, .nrst, .cfg_enable, .test_mode, .reg_wr, .reg_rd,
		.reg_src, .reg_addr, .reg_wdata, .revert_cmd, .hot_swap, .hot_swap_module,
		.param_ack, .param_err, .param_rdata, .reg_ack, .reg_err, .reg_rdata, .param_req,
		.param_we, .param_index, .param_subidx, .param_len, .param_wdata, .param_revert,
		.hot_swap_flag);
	rpa_store_model u_store (.clk, .param_req, .delay, .mode, .rd_val, .param_ack,
		.param_err, .param_rdata);

	// Clock and a count of request pulses, sampled away from the launching edge.
	always #25 clk = ~clk;
	always @(negedge clk) if (param_req === 1'b1) nreq++;

	task automatic results();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One strobe pulse; the answer is taken in the cycle after the taking edge.
	task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		reg_wr = w;
		reg_rd = !w;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		ak = reg_ack;
		er = reg_err;
		q = reg_rdata;
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic e);
		acc(1'b1, a, d);
		chk({ak, er}, {1'b1, e});
	endtask

	task automatic rdc(input logic [15:0] a, input logic [15:0] e);
		acc(1'b0, a, 16'h0000);
		chk({ak, q}, {1'b1, e});
	endtask

	// One parameter access: index and data words first, then word zero with a flipped toggle.
	task automatic req(input logic [6:0] len, input logic [1:0] m);
		logic e;
		idx = 16'($urandom);
		dat = $urandom;
		sub = 8'($urandom);
		rd_val = $urandom;
		delay = 4'($urandom_range(5));
		mode = m;
		tg = ~tg;
		e = len > 7'h04 || m != 2'h0;
		// Expected response words, queued in the order they are read back.
		exp_q.push_back({mod, tg, e, len[2:0]});
		exp_q.push_back(idx);
		exp_q.push_back(len == 0 ? rd_val[15:0] : dat[15:0]);
		exp_q.push_back(len == 0 ? rd_val[31:16] : dat[31:16]);
		wr(16'hB04B, idx, 1'b0);
		wr(16'hB04C, dat[15:0], 1'b0);
		wr(16'hB04D, dat[31:16], 1'b0);
		n = nreq;
		wr(16'hB04A, {sub, tg, len}, 1'b0);
		@(negedge clk);
		chk(param_req, len <= 7'h04);
		if (len <= 7'h04) begin
			chk({param_we, param_len, param_subidx, param_index}, {len != 0, len, sub, idx});
			chk(param_wdata, dat);
		end
		k = 0;
		do begin
			acc(1'b0, 16'hB04F, 16'h0000);
			k++;
		end while (q[7] !== tg && k < 40);
		if (q[7] !== tg) begin
			err_count++;
			results();
		end
		chk({q[15:6], q[2:0]}, exp_q.pop_front());
		chk(nreq - n, len <= 7'h04);
		if (!e) begin
			rdc(16'hB050, 16'(exp_q.pop_front()));
			rdc(16'hB051, 16'(exp_q.pop_front()));
			rdc(16'hB052, 16'(exp_q.pop_front()));
		end else begin
			exp_q.delete();
		end
	endtask

	// Main sequence; the window is reverted only while the toggle rests at zero.
	initial begin
		k = $urandom(99138);
		repeat (8) @(negedge clk);
		nrst = 1'b1;
		chk({param_req, param_revert, hot_swap_flag}, 3'h0);
		for (int i = 0; i < 9; i++) rdc(16'hB04A + 16'(i), 16'h0000);
		acc(1'b0, 16'hB049, 16'h0000);
		chk(ak, 1'b0);
		acc(1'b1, 16'hB053, 16'h5A5A);
		chk(ak, 1'b0);
		cfg_enable = 1'b0;
		acc(1'b0, 16'hB04A, 16'h0000);
		chk(ak, 1'b0);
		cfg_enable = 1'b1;
		wr(16'hB050, 16'h1234, 1'b1);
		rdc(16'hB050, 16'h0000);
		test_mode = 1'b1;
		wr(16'hB04E, 16'hA5C3, 1'b1);
		rdc(16'hB04E, 16'h0000);
		reg_src = rpa_pkg::RPA_SRC_PANEL;
		wr(16'hB04E, 16'hA5C3, 1'b0);
		rdc(16'hB04E, 16'hA5C3);
		test_mode = 1'b0;
		reg_src = rpa_pkg::RPA_SRC_MASTER;
		$display("test map done");
		req(7'h04, 2'h0);
		req(7'h00, 2'h0);
		$display("test requests done");
		@(negedge clk);
		revert_cmd = 1'b1;
		@(negedge clk);
		revert_cmd = 1'b0;
		chk(param_revert, 1'b1);
		hot_swap = 1'b1;
		hot_swap_module = 8'($urandom);
		mod = hot_swap_module;
		@(negedge clk);
		hot_swap = 1'b0;
		chk({param_revert, hot_swap_flag}, 2'h3);
		rdc(16'hB04A, 16'h0000);
		$display("test revert done");
		req(7'h05, 2'h0);
		req(7'($urandom_range(4, 1)), 2'h1);
		chk(hot_swap_flag, 1'b0);
		req(7'h02, 2'h2);
		$display("test faults done");
		results();
	end
endmodule
